/* verilog/spdc_regs.vh */
// register map, field positions and reset values of the spi data/crc block
`ifndef SPDC_REGS_VH
`define SPDC_REGS_VH

`define SPDC_ADDR_W 8
`define SPDC_OFF_CTRL 8'h00
`define SPDC_OFF_STAT 8'h08
`define SPDC_OFF_DATA 8'h0C
`define SPDC_OFF_POLY 8'h10
`define SPDC_OFF_RCRC 8'h14
`define SPDC_OFF_TCRC 8'h18
`define SPDC_OFF_FAST 8'h24

`define SPDC_CTRL_CHK 0
`define SPDC_CTRL_WID 1
`define SPDC_CTRL_BRL 2
`define SPDC_CTRL_BRH 4
`define SPDC_STAT_RNE 0
`define SPDC_STAT_TXE 1
`define SPDC_STAT_BUSY 2
`define SPDC_FAST_EN 0

`define SPDC_POLY_RST 16'h0007
`define SPDC_ZERO16 16'h0000
`define SPDC_ZERO32 32'h0000_0000
`define SPDC_BR_DIV2 3'h0
`define SPDC_BITS8 5'h08
`define SPDC_BITS16 5'h10
`define SPDC_RESP_OKAY 2'h0
`define SPDC_RESP_SLVERR 2'h2
`define SPDC_FIFO_DEPTH 4
`define SPDC_FIFO_AW 2

`endif

/* verilog/spdc_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module spdc_fifo #(
	parameter W = 16,
	parameter D = 4,
	parameter AW = 2
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [W-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [W-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != D[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_valid & out_ready;

	always @(posedge aclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

/* verilog/spdc_crc.v */
// one-frame crc step over 8 or 16 data bits, msb first
`timescale 1ns/1ps
module spdc_crc (
	input wire [15:0] crc_in,
	input wire [15:0] data,
	input wire [15:0] poly,
	input wire wide,
	output reg [15:0] crc_out
);
	integer i;
	reg fb;

	always @* begin
		crc_out = crc_in;
		fb = 1'b0;
		for (i = 15; i >= 0; i = i - 1) begin
			// narrow frames feed only the low byte
			if (wide || i < 8) begin
				fb = crc_out[15] ^ data[i];
				crc_out = {crc_out[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
			end
		end
	end
endmodule

/* verilog/spdc_core.v */
// spi data, crc and fast-receive block with axi4-lite registers
//
// Overview of operation
// - data reads give rx buffer, writes tx
// - 8-bit frames: low byte, upper reads zero
// - 16-bit frames use all data bits
// - 16-bit polynomial register, resets to seven
// - read-only rx crc, resets to zero
// - read-only tx crc, resets to zero
// - setting check enable clears both crcs
// - crc covers 8 or 16 bits per mode
// - fast receive bit enables high-speed sampling
// - fast receive works only at divide-by-two
// - fast receive enable reads back zero
// - busy while shifting or tx buffer not empty
// - data register read clears rx-not-empty
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "spdc_regs.vh"
module spdc_core (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg spi_sck,
	output wire spi_mosi,
	input wire spi_miso,
	output wire transfer_busy
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_DONE = 3'b100;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] strb;
		begin
			merge16 = old;
			if (strb[0]) begin
				merge16[7:0] = wd[7:0];
			end
			if (strb[1]) begin
				merge16[15:8] = wd[15:8];
			end
		end
	endfunction

	// 8-bit frames keep only the low byte
	function [15:0] frame_mask;
		input [15:0] w;
		input wide;
		begin
			frame_mask = wide ? w : {8'h00, w[7:0]};
		end
	endfunction

	reg [2:0] state_reg;
	reg [7:0] aw_addr_reg;
	reg aw_held_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg w_held_reg;
	reg check_enable_reg;
	reg frame_width_select_reg;
	reg [2:0] baud_divider_reg;
	reg fast_receive_enable_reg;
	reg [15:0] check_polynomial_reg;
	reg [15:0] receive_check_value_reg;
	reg [15:0] transmit_check_value_reg;
	reg [15:0] rx_buffer_reg;
	reg receive_not_empty_reg;
	reg [15:0] tx_shift_reg;
	reg [15:0] tx_word_reg;
	reg [15:0] rx_shift_reg;
	reg [4:0] bit_cnt_reg;
	reg [7:0] div_cnt_reg;
	reg [31:0] rd_next;
	reg rd_err_next;

	wire wr_go;
	wire wr_is_data;
	wire wr_known;
	wire rd_go;
	wire rd_is_data;
	wire [15:0] wr_val;
	wire fifo_in_ready;
	wire [15:0] fifo_out_data;
	wire fifo_out_valid;
	wire fifo_pop;
	wire fast_active;
	wire tick;
	wire [7:0] half_period;
	wire [15:0] rx_crc_next;
	wire [15:0] tx_crc_next;
	wire [15:0] rx_word;

	assign wr_is_data = (aw_addr_reg == `SPDC_OFF_DATA);
	assign wr_known = (aw_addr_reg == `SPDC_OFF_CTRL) |
		(aw_addr_reg == `SPDC_OFF_STAT) | wr_is_data |
		(aw_addr_reg == `SPDC_OFF_POLY) |
		(aw_addr_reg == `SPDC_OFF_RCRC) |
		(aw_addr_reg == `SPDC_OFF_TCRC) |
		(aw_addr_reg == `SPDC_OFF_FAST);
	// a full tx fifo holds the write response back, stalling the master
	assign wr_go = ce & aw_held_reg & w_held_reg & ~s_axi_bvalid &
		(~wr_is_data | fifo_in_ready);
	assign s_axi_awready = ce & ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready = ce & ~w_held_reg & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign rd_go = s_axi_arvalid & s_axi_arready;
	assign rd_is_data = (s_axi_araddr == `SPDC_OFF_DATA);
	assign wr_val = w_data_reg[15:0];

	assign fast_active = fast_receive_enable_reg &
		(baud_divider_reg == `SPDC_BR_DIV2);
	assign half_period = 8'h01 << baud_divider_reg;
	assign tick = (div_cnt_reg == half_period - 8'h01);
	assign spi_mosi = tx_shift_reg[15];
	assign fifo_pop = (state_reg == ST_IDLE);
	assign transfer_busy = (state_reg != ST_IDLE) | fifo_out_valid;
	assign rx_word = frame_mask(rx_shift_reg, frame_width_select_reg);

	spdc_fifo #(
		.W(16),
		.D(`SPDC_FIFO_DEPTH),
		.AW(`SPDC_FIFO_AW)
	) u_tx_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.in_data(frame_mask(wr_val, frame_width_select_reg)),
		.in_valid(wr_go & wr_is_data),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop)
	);

	spdc_crc u_rx_crc (
		.crc_in(receive_check_value_reg),
		.data(rx_word),
		.poly(check_polynomial_reg),
		.wide(frame_width_select_reg),
		.crc_out(rx_crc_next)
	);

	spdc_crc u_tx_crc (
		.crc_in(transmit_check_value_reg),
		.data(tx_word_reg),
		.poly(check_polynomial_reg),
		.wide(frame_width_select_reg),
		.crc_out(tx_crc_next)
	);

	// register read mux
	always @* begin
		rd_next = `SPDC_ZERO32;
		rd_err_next = 1'b0;
		case (s_axi_araddr)
		`SPDC_OFF_CTRL: begin
			rd_next[`SPDC_CTRL_CHK] = check_enable_reg;
			rd_next[`SPDC_CTRL_WID] = frame_width_select_reg;
			rd_next[`SPDC_CTRL_BRH:`SPDC_CTRL_BRL] = baud_divider_reg;
		end
		`SPDC_OFF_STAT: begin
			rd_next[`SPDC_STAT_RNE] = receive_not_empty_reg;
			rd_next[`SPDC_STAT_TXE] = ~fifo_out_valid;
			rd_next[`SPDC_STAT_BUSY] = transfer_busy;
		end
		`SPDC_OFF_DATA: rd_next[15:0] = rx_buffer_reg;
		`SPDC_OFF_POLY: rd_next[15:0] = check_polynomial_reg;
		`SPDC_OFF_RCRC: rd_next[15:0] = receive_check_value_reg;
		`SPDC_OFF_TCRC: rd_next[15:0] = transmit_check_value_reg;
		`SPDC_OFF_FAST: rd_next = `SPDC_ZERO32;
		default: rd_err_next = 1'b1;
		endcase
	end

	// axi write and read channels
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_reg <= 8'h00;
			aw_held_reg <= 1'b0;
			w_data_reg <= `SPDC_ZERO32;
			w_strb_reg <= 4'h0;
			w_held_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPDC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `SPDC_RESP_OKAY;
			s_axi_rdata <= `SPDC_ZERO32;
		end else if (ce) begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_held_reg <= 1'b1;
			end
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `SPDC_RESP_OKAY : `SPDC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_next;
				s_axi_rresp <= rd_err_next ? `SPDC_RESP_SLVERR :
					`SPDC_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// control registers; crc offsets take no write at all
	always @(posedge aclk) begin
		if (!aresetn) begin
			check_enable_reg <= 1'b0;
			frame_width_select_reg <= 1'b0;
			baud_divider_reg <= `SPDC_BR_DIV2;
			fast_receive_enable_reg <= 1'b0;
			check_polynomial_reg <= `SPDC_POLY_RST;
		end else if (ce & wr_go) begin
			case (aw_addr_reg)
			`SPDC_OFF_CTRL: begin
				if (w_strb_reg[0]) begin
					check_enable_reg <= wr_val[`SPDC_CTRL_CHK];
					frame_width_select_reg <= wr_val[`SPDC_CTRL_WID];
					baud_divider_reg <=
						wr_val[`SPDC_CTRL_BRH:`SPDC_CTRL_BRL];
				end
			end
			`SPDC_OFF_POLY: begin
				check_polynomial_reg <=
					merge16(check_polynomial_reg, w_data_reg, w_strb_reg);
			end
			`SPDC_OFF_FAST: begin
				if (w_strb_reg[0]) begin
					fast_receive_enable_reg <= wr_val[`SPDC_FAST_EN];
				end
			end
			default: begin
				check_enable_reg <= check_enable_reg;
			end
			endcase
		end
	end

	// serial shifter, mode 0, msb first
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			spi_sck <= 1'b0;
			tx_shift_reg <= `SPDC_ZERO16;
			tx_word_reg <= `SPDC_ZERO16;
			rx_shift_reg <= `SPDC_ZERO16;
			bit_cnt_reg <= 5'h00;
			div_cnt_reg <= 8'h00;
		end else if (ce) begin
			case (state_reg)
			ST_IDLE: begin
				spi_sck <= 1'b0;
				div_cnt_reg <= 8'h00;
				if (fifo_out_valid) begin
					tx_word_reg <= fifo_out_data;
					// narrow frames start at bit 7
					tx_shift_reg <= frame_width_select_reg ? fifo_out_data :
						{fifo_out_data[7:0], 8'h00};
					bit_cnt_reg <= frame_width_select_reg ? `SPDC_BITS16 :
						`SPDC_BITS8;
					state_reg <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				div_cnt_reg <= tick ? 8'h00 : div_cnt_reg + 8'h01;
				if (tick) begin
					spi_sck <= ~spi_sck;
					// fast mode samples half a clock later, on the
					// falling edge, to absorb the input delay at /2
					if (spi_sck == fast_active) begin
						rx_shift_reg <= {rx_shift_reg[14:0], spi_miso};
					end
					if (spi_sck) begin
						tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg - 5'h01;
						if (bit_cnt_reg == 5'h01) begin
							state_reg <= ST_DONE;
						end
					end
				end
			end
			ST_DONE: begin
				state_reg <= ST_IDLE;
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// receive buffer, flag and crc accumulators
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_buffer_reg <= `SPDC_ZERO16;
			receive_not_empty_reg <= 1'b0;
			receive_check_value_reg <= `SPDC_ZERO16;
			transmit_check_value_reg <= `SPDC_ZERO16;
		end else if (ce) begin
			if (state_reg == ST_DONE) begin
				rx_buffer_reg <= rx_word;
				receive_not_empty_reg <= 1'b1;
			end else if (rd_go & rd_is_data) begin
				receive_not_empty_reg <= 1'b0;
			end
			if (wr_go & (aw_addr_reg == `SPDC_OFF_CTRL) & w_strb_reg[0] &
				wr_val[`SPDC_CTRL_CHK] & ~check_enable_reg) begin
				receive_check_value_reg <= `SPDC_ZERO16;
				transmit_check_value_reg <= `SPDC_ZERO16;
			end else if ((state_reg == ST_DONE) & check_enable_reg) begin
				receive_check_value_reg <= rx_crc_next;
				transmit_check_value_reg <= tx_crc_next;
			end
		end
	end
endmodule

/* dv/spdc_core_assertions.sv */
// port checker for the spi data/crc block
`timescale 1ns/1ps
module spdc_core_chk (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire spi_sck,
	input wire spi_mosi,
	input wire transfer_busy
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
	r_time_a: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read answer late");
	ar_wait_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	aw_wait_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answering");
	sck_busy_a: assert property (spi_sck |-> transfer_busy)
		else $error("clock without busy");
	busy_end_a: assert property ($fell(transfer_busy)
		|-> !spi_sck && !$past(spi_sck)) else $error("busy fell early");
	mosi_edge_a: assert property ($changed(spi_mosi) |-> !spi_sck)
		else $error("mosi moved with clock high");
	fast_zero_a: assert property (ar_hs && s_axi_araddr == 8'h24
		|=> s_axi_rdata == 32'h0000_0000) else $error("fast bit readable");
	cover property ($fell(transfer_busy));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (ar_hs && s_axi_araddr == 8'h0c);
endmodule
bind spdc_core spdc_core_chk u_chk (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .spi_sck, .spi_mosi, .transfer_busy);

/* dv/spdc_slave_model.sv */
// behavioural spi slave, mode 0, msb first
`timescale 1ns/1ps
module spdc_slave_model (
	input wire spi_sck,
	input wire spi_mosi,
	input wire wide,
	input wire [15:0] reply,
	output wire spi_miso,
	output logic [15:0] got,
	output int frames
);
	int m = 0;
	initial frames = 0;
	// next bit stands from one falling edge to the next
	assign spi_miso = reply[(wide ? 15 : 7) - m];
	always @(posedge spi_sck)
		got = (m == 0) ? {15'h0000, spi_mosi} : {got[14:0], spi_mosi};
	always @(negedge spi_sck) begin
		m = m + 1;
		if (m == (wide ? 16 : 8)) begin
			m = 0;
			frames = frames + 1;
		end
	end
endmodule

/* dv/spdc_core_tb.sv */
// self-checking bench for the spi data/crc block
`timescale 1ns/1ps
module spdc_core_tb;
	localparam logic [31:0] z = 32'h0000_0000;
	localparam logic [1:0] ok = 2'h0;
	logic aclk = 0, aresetn = 0, ce = 1, wide = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic spi_sck, spi_mosi, spi_miso, transfer_busy;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] reply = 0, got, crc_r = 0, crc_t = 0, poly = 16'h1021;
	int num_errors = 0, comparisons = 0, frames, n;
	always #2.5 aclk = ~aclk;
	spdc_core dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .spi_sck, .spi_mosi, .spi_miso, .transfer_busy);
	spdc_slave_model peer (.spi_sck, .spi_mosi, .wide, .reply, .spi_miso,
		.got, .frames);
	task automatic check(input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		check(s_axi_bresp, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		check(s_axi_rdata, e);
		check(s_axi_rresp, r);
	endtask
	task automatic idle;
		do @(posedge aclk); while (transfer_busy !== 1'b0);
	endtask
	// own msb-first model, not shared with the design
	function automatic logic [15:0] crc(input logic [15:0] c, d, int k);
		for (int i = k - 1; i >= 0; i--)
			c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ poly : {c[14:0], 1'b0};
		return c;
	endfunction
	task automatic frame(input logic w, input logic [15:0] d, r);
		reply <= r;
		wide <= w;
		wr(8'h0c, {16'h0000, d}, ok);
		idle();
		crc_t = crc(crc_t, d, w ? 16 : 8);
		crc_r = crc(crc_r, r, w ? 16 : 8);
		check(got, w ? d : d[7:0]);
		rd(8'h08, 32'h0000_0003, ok);
		rd(8'h0c, w ? r : r[7:0], ok);
		rd(8'h08, 32'h0000_0002, ok);
		rd(8'h14, crc_r, ok);
		rd(8'h18, crc_t, ok);
	endtask
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#150000;
		num_errors++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rd(8'h10, 32'h0000_0007, ok);
		rd(8'h14, z, ok);
		rd(8'h18, z, ok);
		rd(8'h0c, z, ok);
		wr(8'h10, 32'h0000_1021, ok);
		rd(8'h10, 32'h0000_1021, ok);
		wr(8'h14, 32'h0000_ffff, ok);
		wr(8'h18, 32'h0000_ffff, ok);
		rd(8'h14, z, ok);
		rd(8'h18, z, ok);
		wr(8'h30, 32'h0000_0001, 2'h2);
		rd(8'h30, z, 2'h2);
		wr(8'h24, 32'h0000_0001, ok);
		rd(8'h24, z, ok);
		// a frozen block refuses every request
		ce <= 0;
		@(posedge aclk);
		check(s_axi_arready, 0);
		check(s_axi_awready, 0);
		ce <= 1;
		$display("register test done");
		// narrow frames at divide by two, fast receive on
		wr(8'h00, 32'h0000_0001, ok);
		frame(0, 16'h01a5, 16'hc33c);
		frame(0, 16'h00ff, 16'h0081);
		wr(8'h00, z, ok);
		wr(8'h00, 32'h0000_0007, ok);
		crc_r = 0;
		crc_t = 0;
		frame(1, 16'hbeef, 16'h1234);
		frame(1, 16'h8001, 16'hf00d);
		$display("frame test done");
		// six words into a four-deep buffer: the sixth write stalls
		wr(8'h00, 32'h0000_0009, ok);
		reply <= 16'h005a;
		wide <= 0;
		n = frames;
		for (int i = 0; i < 6; i++) begin
			wr(8'h0c, 32'h0000_0010 + i, ok);
			check(transfer_busy, 1);
			crc_t = crc(crc_t, 16'h0010 + i, 8);
			crc_r = crc(crc_r, 16'h005a, 8);
		end
		idle();
		check(frames - n, 6);
		rd(8'h0c, 32'h0000_005a, ok);
		rd(8'h08, 32'h0000_0002, ok);
		rd(8'h14, crc_r, ok);
		rd(8'h18, crc_t, ok);
		$display("buffer test done");
		conclude();
	end
endmodule
